// *** qbs_ctrl_end.sv ***
`timescale 1ns/1ps
`default_nettype none
module qbs_ctrl_end #(
   parameter int DW = qbs_pkg::DATA_W,
   parameter int AW = qbs_pkg::ADDR_W,
   parameter int NL = DW / qbs_pkg::LANE_W,
   parameter int DEPTH = qbs_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // link to the memory
   qbs_link_if.ctrl link,
   // mode strap
   input wire logic pll_disable_n_i,
   // read requests and returned data
   input wire logic rd_req_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic rd_ack_o,
   output logic [DW-1:0] rd_data_o,
   output logic rd_data_valid_o,
   // write requests
   input wire logic wr_req_i,
   input wire logic [AW-1:0] wr_addr_i,
   output logic wr_ack_o,
   // write data stream
   input wire logic wr_data_valid_i,
   input wire logic [DW-1:0] wr_data_i,
   input wire logic [NL-1:0] wr_mask_n_i,
   output logic wr_data_ready_o
);
   localparam int LW = $clog2(DEPTH + 1);

   qbs_pkg::qbs_cmd_e rd_st, wr_st, next_rd_st, next_wr_st;
   logic k, k_n, rps_n, wps_n, rd_ack, wr_ack, rd_vld, wpre, pll_dis_n;
   logic next_k, next_rps_n, next_wps_n, next_rd_ack, next_wr_ack, next_rd_vld, next_wpre;
   logic [AW-1:0] addr, next_addr;
   logic [DW-1:0] d, next_d, rd_data, next_rd_data;
   logic [NL-1:0] mask_n, next_mask_n;
   logic [1:0] wrem, next_wrem;
   logic rd_go, wr_go, pop, f_valid;
   logic [NL+DW-1:0] f_data;
   logic [LW-1:0] level;
   int owed;

   // write words wait here until a burst pulls them
   qbs_fifo #(.W(NL + DW), .DEPTH(DEPTH)) u_wbuf (
      .mclk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .in_valid_i(wr_data_valid_i),
      .in_ready_o(wr_data_ready_o),
      .in_data_i({wr_mask_n_i, wr_data_i}),
      .out_valid_o(f_valid),
      .out_ready_i(pop),
      .out_data_o(f_data),
      .level_o(level)
   );

   // command slots, spacing, write data beats and read capture
   always_comb begin
      next_k = ~k;
      owed = int'(wrem) + (wpre ? qbs_pkg::BURST_LEN : 0)
             + (!wps_n ? qbs_pkg::BURST_LEN : 0);
      // commands go out only on positive-clock beats, read first
      rd_go = !k && (rd_st == qbs_pkg::CMD_IDLE) && rd_req_i;
      wr_go = !k && (wr_st == qbs_pkg::CMD_IDLE) && wr_req_i && !rd_go
              && (int'(level) >= qbs_pkg::BURST_LEN + owed);
      next_rps_n = !rd_go;
      next_wps_n = !wr_go;
      next_addr = rd_go ? rd_addr_i : (wr_go ? wr_addr_i : addr);
      next_rd_ack = rd_go;
      next_wr_ack = wr_go;
      // one command every two positive edges per port
      next_rd_st = rd_st;
      next_wr_st = wr_st;
      case (rd_st)
         qbs_pkg::CMD_IDLE: if (rd_go) next_rd_st = qbs_pkg::CMD_SEL;
         qbs_pkg::CMD_SEL: next_rd_st = qbs_pkg::CMD_GAP;
         qbs_pkg::CMD_GAP: if (k) next_rd_st = qbs_pkg::CMD_IDLE;
         default: next_rd_st = qbs_pkg::CMD_IDLE;
      endcase
      case (wr_st)
         qbs_pkg::CMD_IDLE: if (wr_go) next_wr_st = qbs_pkg::CMD_SEL;
         qbs_pkg::CMD_SEL: next_wr_st = qbs_pkg::CMD_GAP;
         qbs_pkg::CMD_GAP: if (k) next_wr_st = qbs_pkg::CMD_IDLE;
         default: next_wr_st = qbs_pkg::CMD_IDLE;
      endcase
      // four data words from the positive edge after the command
      next_wpre = !wps_n;
      pop = (wpre || (wrem != '0)) && f_valid;
      next_wrem = wpre ? qbs_pkg::BEAT_LAST : (wrem != '0 ? wrem - 1'b1 : wrem);
      next_d = pop ? f_data[DW-1:0] : '0;
      next_mask_n = pop ? f_data[NL+DW-1:DW] : '1;
      // read words are taken while the valid indicator is high
      next_rd_vld = link.read_output_valid;
      next_rd_data = link.read_output_valid ? link.q_wire : rd_data;
   end

   // link and user registers
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         k <= 1'b0;
         k_n <= 1'b1;
         rps_n <= 1'b1;
         wps_n <= 1'b1;
         addr <= '0;
         d <= '0;
         mask_n <= '1;
         rd_st <= qbs_pkg::CMD_IDLE;
         wr_st <= qbs_pkg::CMD_IDLE;
         rd_ack <= 1'b0;
         wr_ack <= 1'b0;
         rd_vld <= 1'b0;
         rd_data <= '0;
         wpre <= 1'b0;
         wrem <= '0;
         pll_dis_n <= 1'b1;
      end else begin
         k <= next_k;
         k_n <= k;
         rps_n <= next_rps_n;
         wps_n <= next_wps_n;
         addr <= next_addr;
         d <= next_d;
         mask_n <= next_mask_n;
         rd_st <= next_rd_st;
         wr_st <= next_wr_st;
         rd_ack <= next_rd_ack;
         wr_ack <= next_wr_ack;
         rd_vld <= next_rd_vld;
         rd_data <= next_rd_data;
         wpre <= next_wpre;
         wrem <= next_wrem;
         pll_dis_n <= pll_disable_n_i;
      end
   end

   assign link.k_pos = k;
   assign link.k_neg = k_n;
   assign link.addr = addr;
   assign link.read_port_select_n = rps_n;
   assign link.write_port_select_n = wps_n;
   assign link.d = d;
   assign link.byte_lane_write_mask_n = mask_n;
   assign link.pll_disable_n = pll_dis_n;
   assign rd_ack_o = rd_ack;
   assign wr_ack_o = wr_ack;
   assign rd_data_o = rd_data;
   assign rd_data_valid_o = rd_vld;
endmodule : qbs_ctrl_end
`default_nettype wire

// *** qbs_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module qbs_fifo #(
   parameter int W = 20,
   parameter int DEPTH = qbs_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o,
   output logic [$clog2(DEPTH+1)-1:0] level_o
);
   localparam int PW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
   localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

   logic [W-1:0] mem [0:DEPTH-1];
   logic [PW-1:0] wptr, rptr, next_wptr, next_rptr;
   logic [CW-1:0] count, next_count;
   logic not_full, next_not_full;
   logic push, pop;

   // handshakes and next pointer values
   always_comb begin
      push = in_valid_i && not_full;
      pop = out_ready_i && (count != '0);
      next_wptr = wptr;
      next_rptr = rptr;
      next_count = count;
      if (push) begin
         next_wptr = (wptr == PTR_LAST) ? '0 : wptr + 1'b1;
      end
      if (pop) begin
         next_rptr = (rptr == PTR_LAST) ? '0 : rptr + 1'b1;
      end
      if (push && !pop) begin
         next_count = count + 1'b1;
      end else if (pop && !push) begin
         next_count = count - 1'b1;
      end
      next_not_full = (next_count != CNT_FULL);
   end

   // pointer and level registers
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wptr <= '0;
         rptr <= '0;
         count <= '0;
         not_full <= 1'b1;
      end else begin
         wptr <= next_wptr;
         rptr <= next_rptr;
         count <= next_count;
         not_full <= next_not_full;
      end
   end

   // storage
   always_ff @(posedge mclk_i) begin
      if (push) begin
         mem[wptr] <= in_data_i;
      end
   end

   assign in_ready_o = not_full;
   assign out_valid_o = (count != '0);
   assign out_data_o = mem[rptr];
   assign level_o = count;
endmodule : qbs_fifo
`default_nettype wire

// *** qbs_link_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface qbs_link_if #(
   parameter int DW = qbs_pkg::DATA_W,
   parameter int AW = qbs_pkg::ADDR_W,
   parameter int NL = DW / qbs_pkg::LANE_W
) (
   input wire logic mclk_i
);
   // clock pair, controls and address from the controller
   logic k_pos;
   logic k_neg;
   logic [AW-1:0] addr;
   logic read_port_select_n;
   logic write_port_select_n;
   logic [DW-1:0] d;
   logic [NL-1:0] byte_lane_write_mask_n;
   logic pll_disable_n;
   // read side from the memory
   logic [DW-1:0] q;
   logic q_oe_n;
   logic read_output_valid;
   logic echo_clock_out;
   logic echo_clock_out_n;
   wire [DW-1:0] q_wire;

   // read data as the controller sees it; released outputs show the inverse of the last word
   assign q_wire = q_oe_n ? ~q : q;

   modport sram (
      input k_pos, k_neg, addr, read_port_select_n, write_port_select_n, d,
      input byte_lane_write_mask_n, pll_disable_n,
      output q, q_oe_n, read_output_valid, echo_clock_out, echo_clock_out_n
   );
   modport ctrl (
      output k_pos, k_neg, addr, read_port_select_n, write_port_select_n, d,
      output byte_lane_write_mask_n, pll_disable_n,
      input q_wire, read_output_valid, echo_clock_out, echo_clock_out_n
   );
endinterface : qbs_link_if
`default_nettype wire

// *** qbs_link_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module qbs_link_props (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // controller side of the link
   input wire logic k_pos,
   input wire logic k_neg,
   input wire logic read_port_select_n,
   input wire logic write_port_select_n,
   input wire logic pll_disable_n,
   // memory side of the link
   input wire logic q_oe_n,
   input wire logic read_output_valid,
   input wire logic echo_clock_out,
   input wire logic echo_clock_out_n
);
   // one clock domain, all checks quiet while reset is low
   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   // clock pair stays complementary and flips every beat
   property p_kclk;
      $past(rst_n_i) |-> (k_pos != $past(k_pos)) && (k_neg == !k_pos);
   endproperty
   a_kclk: assert property (p_kclk)
      else $error("clock pair not toggling as a complementary pair");

   // echo pair follows the positive clock one beat later, never stops
   property p_echo;
      (echo_clock_out == $past(k_pos)) && (echo_clock_out_n == !echo_clock_out);
   endproperty
   a_echo: assert property (p_echo)
      else $error("echo clock pair not following the input clock");

   // read select is a positive beat pulse, next one two positive beats later at least
   property p_rd_sel;
      !read_port_select_n |-> k_pos ##1 read_port_select_n [*3];
   endproperty
   a_rd_sel: assert property (p_rd_sel)
      else $error("read select off a positive beat or too close");

   // write select keeps the same spacing on its own port
   property p_wr_sel;
      !write_port_select_n |-> k_pos ##1 write_port_select_n [*3];
   endproperty
   a_wr_sel: assert property (p_wr_sel)
      else $error("write select off a positive beat or too close");

   // pll on: four valid words starting two and a half cycles after the command
   property p_rd_on;
      !read_port_select_n && pll_disable_n |-> ##5 read_output_valid [*4];
   endproperty
   a_rd_on: assert property (p_rd_on)
      else $error("read words late or short with pll on");

   // pll off: four valid words starting one cycle after the command
   property p_rd_off;
      !read_port_select_n && !pll_disable_n |-> ##2 read_output_valid [*4];
   endproperty
   a_rd_off: assert property (p_rd_off)
      else $error("read words late or short with pll off");

   // read data is driven whenever it is flagged valid
   property p_drive;
      read_output_valid |-> !q_oe_n;
   endproperty
   a_drive: assert property (p_drive)
      else $error("valid read word while outputs float");

   // outputs float on the beat after the last word of a four-word run
   property p_float;
      $fell(read_output_valid) |-> q_oe_n && $past(read_output_valid, 4);
   endproperty
   a_float: assert property (p_float)
      else $error("read outputs still driven after the burst");

   // first valid word lands on the echo phase that matches the mode
   property p_valid_echo;
      $rose(read_output_valid) |-> echo_clock_out == pll_disable_n;
   endproperty
   a_valid_echo: assert property (p_valid_echo)
      else $error("valid flag not aligned with the echo clock");
endmodule : qbs_link_props
`default_nettype wire

// *** qbs_pkg.sv ***
`default_nettype none
package qbs_pkg;
   // link widths for the 18-bit configuration
   localparam int DATA_W = 18;
   localparam int ADDR_W = 20;
   localparam int LANE_W = 9;
   // burst shape
   localparam int BURST_LEN = 4;
   localparam int BEAT_W = 2;
   localparam logic [1:0] BEAT_FIRST = 2'h0;
   localparam logic [1:0] BEAT_SECOND = 2'h1;
   localparam logic [1:0] BEAT_LAST = 2'h3;
   // latencies in half-cycle beats: 2.5 cycles, 1 cycle, write data one cycle on
   localparam int RD_LAT_PLL = 5;
   localparam int RD_LAT_OFF = 2;
   localparam int WR_LAT = 2;
   localparam int DLY_LEN = 4;
   // clocking: one beat per system clock, pll-off limit in MHz
   localparam int CLK_MHZ = 250;
   localparam int PLL_OFF_MAX_MHZ = 167;
   // write data buffer
   localparam int FIFO_DEPTH = 8;
   // command sequencer states
   typedef enum logic [2:0] {
      CMD_IDLE = 3'h1,
      CMD_SEL = 3'h2,
      CMD_GAP = 3'h4
   } qbs_cmd_e;
endpackage : qbs_pkg
`default_nettype wire

// *** qbs_sram_end.sv ***
`timescale 1ns/1ps
`default_nettype none
// How it works
// - low lane mask stores the lane each beat
// - 18-bit: lanes cover 8:0 and 17:9
// - 36-bit: four lanes of nine bits
// - mask and data taken on same beat
// - high mask keeps the stored lane
// - one address bus, sampled at command edge
// - address 20 or 19 bits, one burst
// - address ignored without a port select
// - controller may permute address bits freely
// - read words on both clock edges
// - low read select starts a read burst
// - deselected: finish burst, then float outputs
// - read is four sequential burst words
// - valid flag edge aligned with echo clocks
// - accesses start on positive clock edge
// - negative edge carries second-half beats
// - free running complementary echo clocks
// - pll disable low selects one-cycle mode
// - first word 2.5 cycles, else 1
// - read on the next positive edge ignored
// - low write select starts a write
// - four write words; back-to-back write ignored
module qbs_sram_end #(
   parameter int DW = qbs_pkg::DATA_W,
   parameter int AW = qbs_pkg::ADDR_W,
   parameter int NL = DW / qbs_pkg::LANE_W
) (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // link to the controller
   qbs_link_if.sram link,
   // status
   output logic pll_on_o,
   output logic rd_active_o,
   output logic wr_active_o
);
   localparam int MW = AW + qbs_pkg::BEAT_W;
   localparam int LW = qbs_pkg::LANE_W;
   localparam int DL = qbs_pkg::DLY_LEN;
   localparam logic [1:0] TAP_RD_PLL = 2'(qbs_pkg::RD_LAT_PLL - 2);
   localparam logic [1:0] TAP_RD_OFF = 2'(qbs_pkg::RD_LAT_OFF - 2);
   localparam logic [1:0] TAP_WR = 2'(qbs_pkg::WR_LAT - 1);
   localparam logic [1:0] TAP_BUSY = 2'h1;

   // mode and echo clock state
   logic pll_on, next_pll_on, echo, next_echo;
   // read command delay line, address ring and burst counter
   logic [DL-1:0] r_sr_v, r_sr_tag, next_r_sr_v, next_r_sr_tag;
   logic [AW-1:0] r_ring [0:1];
   logic [AW-1:0] next_r_ring [0:1];
   logic r_wptr, next_r_wptr, r_act, next_r_act;
   logic [1:0] r_idx, next_r_idx;
   logic [AW-1:0] r_addr, next_r_addr;
   // read output registers
   logic [DW-1:0] q, next_q;
   logic q_oe_n, next_q_oe_n, vld, next_vld;
   // write command delay line, address ring and burst counter
   logic [DL-1:0] w_sr_v, w_sr_tag, next_w_sr_v, next_w_sr_tag;
   logic [AW-1:0] w_ring [0:1];
   logic [AW-1:0] next_w_ring [0:1];
   logic w_wptr, next_w_wptr, w_act, next_w_act;
   logic [1:0] w_idx, next_w_idx;
   logic [AW-1:0] w_addr, next_w_addr;
   // per-beat decode
   logic pos_beat, rd_take, wr_take, rd_emerge, wr_emerge, rd_beat, wr_beat;
   logic [1:0] r_tap;
   logic [MW-1:0] rd_loc, wr_loc;
   logic [DW-1:0] rd_word;

   // beat phase, command acceptance and burst start
   always_comb begin
      pos_beat = link.k_pos && !link.k_neg;
      // a command one positive edge after the last is dropped
      rd_take = pos_beat && !link.read_port_select_n && !r_sr_v[TAP_BUSY];
      wr_take = pos_beat && !link.write_port_select_n && !w_sr_v[TAP_BUSY];
      r_tap = pll_on ? TAP_RD_PLL : TAP_RD_OFF;
      rd_emerge = r_sr_v[r_tap];
      wr_emerge = w_sr_v[TAP_WR];
      rd_beat = rd_emerge || r_act;
      wr_beat = wr_emerge || w_act;
      // sequential word order inside the burst
      rd_loc = rd_emerge ? {r_ring[r_sr_tag[r_tap]], qbs_pkg::BEAT_FIRST}
                         : {r_addr, r_idx};
      wr_loc = wr_emerge ? {w_ring[w_sr_tag[TAP_WR]], qbs_pkg::BEAT_FIRST}
                         : {w_addr, w_idx};
   end

   // read pipeline next state
   always_comb begin
      next_r_sr_v = {r_sr_v[DL-2:0], rd_take};
      next_r_sr_tag = {r_sr_tag[DL-2:0], r_wptr};
      next_r_ring = r_ring;
      next_r_wptr = r_wptr;
      // address only captured with the read select low
      if (rd_take) begin
         next_r_ring[r_wptr] = link.addr;
         next_r_wptr = ~r_wptr;
      end
      next_r_act = r_act;
      next_r_idx = r_idx;
      next_r_addr = r_addr;
      if (rd_emerge) begin
         next_r_act = 1'b1;
         next_r_idx = qbs_pkg::BEAT_SECOND;
         next_r_addr = r_ring[r_sr_tag[r_tap]];
      end else if (r_act) begin
         if (r_idx == qbs_pkg::BEAT_LAST) begin
            next_r_act = 1'b0;
         end else begin
            next_r_idx = r_idx + 1'b1;
         end
      end
      // one word per beat, outputs float once the burst is done
      next_q = rd_beat ? rd_word : q;
      next_q_oe_n = !rd_beat;
      next_vld = rd_beat;
   end

   // write pipeline next state
   always_comb begin
      next_w_sr_v = {w_sr_v[DL-2:0], wr_take};
      next_w_sr_tag = {w_sr_tag[DL-2:0], w_wptr};
      next_w_ring = w_ring;
      next_w_wptr = w_wptr;
      // address only captured with the write select low
      if (wr_take) begin
         next_w_ring[w_wptr] = link.addr;
         next_w_wptr = ~w_wptr;
      end
      next_w_act = w_act;
      next_w_idx = w_idx;
      next_w_addr = w_addr;
      if (wr_emerge) begin
         next_w_act = 1'b1;
         next_w_idx = qbs_pkg::BEAT_SECOND;
         next_w_addr = w_ring[w_sr_tag[TAP_WR]];
      end else if (w_act) begin
         if (w_idx == qbs_pkg::BEAT_LAST) begin
            next_w_act = 1'b0;
         end else begin
            next_w_idx = w_idx + 1'b1;
         end
      end
   end

   // mode strap and echo clock
   always_comb begin
      next_pll_on = link.pll_disable_n;
      next_echo = link.k_pos;
   end

   // state registers
   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pll_on <= 1'b1;
         echo <= 1'b0;
         r_sr_v <= '0;
         r_sr_tag <= '0;
         r_ring[0] <= '0;
         r_ring[1] <= '0;
         r_wptr <= 1'b0;
         r_act <= 1'b0;
         r_idx <= qbs_pkg::BEAT_FIRST;
         r_addr <= '0;
         q <= '0;
         q_oe_n <= 1'b1;
         vld <= 1'b0;
         w_sr_v <= '0;
         w_sr_tag <= '0;
         w_ring[0] <= '0;
         w_ring[1] <= '0;
         w_wptr <= 1'b0;
         w_act <= 1'b0;
         w_idx <= qbs_pkg::BEAT_FIRST;
         w_addr <= '0;
      end else begin
         pll_on <= next_pll_on;
         echo <= next_echo;
         r_sr_v <= next_r_sr_v;
         r_sr_tag <= next_r_sr_tag;
         r_ring <= next_r_ring;
         r_wptr <= next_r_wptr;
         r_act <= next_r_act;
         r_idx <= next_r_idx;
         r_addr <= next_r_addr;
         q <= next_q;
         q_oe_n <= next_q_oe_n;
         vld <= next_vld;
         w_sr_v <= next_w_sr_v;
         w_sr_tag <= next_w_sr_tag;
         w_ring <= next_w_ring;
         w_wptr <= next_w_wptr;
         w_act <= next_w_act;
         w_idx <= next_w_idx;
         w_addr <= next_w_addr;
      end
   end

   // one storage array per nine-bit lane, each gated by its own mask
   for (genvar l = 0; l < NL; l++) begin : g_lane
      logic [LW-1:0] lane_mem [0:(2**MW)-1];
      always_ff @(posedge mclk_i) begin
         if (wr_beat && !link.byte_lane_write_mask_n[l]) begin
            lane_mem[wr_loc] <= link.d[l*LW +: LW];
         end
      end
      assign rd_word[l*LW +: LW] = lane_mem[rd_loc];
   end

   assign link.q = q;
   assign link.q_oe_n = q_oe_n;
   assign link.read_output_valid = vld;
   assign link.echo_clock_out = echo;
   assign link.echo_clock_out_n = ~echo;
   assign pll_on_o = pll_on;
   assign rd_active_o = r_act;
   assign wr_active_o = w_act;
endmodule : qbs_sram_end
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   localparam int AW = 6;
   localparam int DW = qbs_pkg::DATA_W;
   localparam int NL = DW / qbs_pkg::LANE_W;
   // stimulus and observed signals
   logic mclk_i = 0;
   logic rst_n_i = 0;
   logic pll_disable_n_i = 1;
   logic rd_req_i = 0;
   logic wr_req_i = 0;
   logic wr_data_valid_i = 0;
   logic mk = 0;
   logic [AW-1:0] rd_addr_i = '0;
   logic [AW-1:0] wr_addr_i = '0;
   logic [DW-1:0] wr_data_i = '0;
   logic [NL-1:0] wr_mask_n_i = '1;
   logic rd_ack_o, rd_data_valid_o, wr_ack_o, wr_data_ready_o;
   logic pll_on_o, rd_active_o, wr_active_o;
   logic [DW-1:0] rd_data_o;
   int errors = 0;
   int checked = 0;
   int seed = 32'ha467;
   int r;
   // bursts issued and active burst beats seen
   int nrd = 0, nwr = 0, ract = 0, wact = 0;
   // reference memory, pending write words {mask, data}, expected read words
   logic [DW-1:0] mem [0:(1<<(AW+2))-1];
   logic [DW+NL-1:0] pq[$];
   logic [DW-1:0] eq[$];

   // 250 MHz system clock
   always #2 mclk_i = ~mclk_i;

   qbs_link_if #(.DW(DW), .AW(AW), .NL(NL)) lnk (.mclk_i(mclk_i));
   qbs_ctrl_end #(.DW(DW), .AW(AW), .NL(NL), .DEPTH(qbs_pkg::FIFO_DEPTH)) qbs_ctrl_end_inst (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(lnk), .pll_disable_n_i(pll_disable_n_i),
      .rd_req_i(rd_req_i), .rd_addr_i(rd_addr_i), .rd_ack_o(rd_ack_o), .rd_data_o(rd_data_o),
      .rd_data_valid_o(rd_data_valid_o), .wr_req_i(wr_req_i), .wr_addr_i(wr_addr_i),
      .wr_ack_o(wr_ack_o), .wr_data_valid_i(wr_data_valid_i), .wr_data_i(wr_data_i),
      .wr_mask_n_i(wr_mask_n_i), .wr_data_ready_o(wr_data_ready_o));
   qbs_sram_end #(.DW(DW), .AW(AW), .NL(NL)) qbs_sram_end_inst (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .link(lnk), .pll_on_o(pll_on_o),
      .rd_active_o(rd_active_o), .wr_active_o(wr_active_o));
   qbs_link_props qbs_link_props_inst (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .k_pos(lnk.k_pos), .k_neg(lnk.k_neg),
      .read_port_select_n(lnk.read_port_select_n),
      .write_port_select_n(lnk.write_port_select_n), .pll_disable_n(lnk.pll_disable_n),
      .q_oe_n(lnk.q_oe_n), .read_output_valid(lnk.read_output_valid),
      .echo_clock_out(lnk.echo_clock_out), .echo_clock_out_n(lnk.echo_clock_out_n));

   // verdict and end of run
   task summarize;
      $display("checks %0d mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : summarize

   // one comparison
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // push up to n words, giving up after lim beats of refusal
   task automatic push(input int n, input int lim);
      int k;
      for (int i = 0; i < n; i++) begin
         k = 0;
         while (wr_data_ready_o !== 1'b1 && k < lim) begin
            @(negedge mclk_i);
            k++;
         end
         if (k == lim) break;
         wr_data_valid_i = 1;
         wr_data_i = DW'($random(seed));
         wr_mask_n_i = mk ? NL'($random(seed)) : '0;
         pq.push_back({wr_mask_n_i, wr_data_i});
         @(negedge mclk_i);
      end
      wr_data_valid_i = 0;
   endtask : push

   // bounded wait for a request acknowledge
   task automatic wait_ack(input bit isrd);
      for (int k = 0; k < 60; k++) begin
         @(negedge mclk_i);
         if ((isrd ? rd_ack_o : wr_ack_o) === 1'b1) begin
            // drop the request so the next free slot does not repeat it
            if (isrd)
               rd_req_i = 0;
            else
               wr_req_i = 0;
            @(negedge mclk_i);
            return;
         end
      end
      chk("request acknowledge", 1, 0);
      summarize();
   endtask : wait_ack

   // write burst: four queued words go to the burst, low mask lanes only
   task automatic wr(input logic [AW-1:0] a);
      logic [DW+NL-1:0] w;
      wr_req_i = 1;
      wr_addr_i = a;
      wait_ack(0);
      nwr++;
      for (int i = 0; i < 4; i++) begin
         w = pq.pop_front();
         for (int l = 0; l < NL; l++)
            if (!w[DW+l]) mem[a*4+i][l*qbs_pkg::LANE_W +: qbs_pkg::LANE_W] = w[l*9 +: 9];
      end
   endtask : wr

   // read burst: expect four words in burst order
   task automatic rd(input logic [AW-1:0] a);
      rd_req_i = 1;
      rd_addr_i = a;
      wait_ack(1);
      nrd++;
      for (int i = 0; i < 4; i++) eq.push_back(mem[a*4+i]);
   endtask : rd

   // drop requests and let n beats pass
   task automatic idle(input int n);
      rd_req_i = 0;
      wr_req_i = 0;
      repeat (n) @(negedge mclk_i);
   endtask : idle

   // every returned word is compared with the reference
   always @(negedge mclk_i) begin
      if (rst_n_i === 1'b1 && rd_active_o === 1'b1) ract++;
      if (rst_n_i === 1'b1 && wr_active_o === 1'b1) wact++;
      if (rst_n_i === 1'b1 && rd_data_valid_o === 1'b1) begin
         if (eq.size() == 0)
            chk("surplus read word", 0, 1);
         else
            chk("read word", eq.pop_front(), rd_data_o);
      end
   end

   // main sequence
   initial begin
      repeat (4) @(negedge mclk_i);
      rst_n_i = 1;
      @(negedge mclk_i);
      chk("pll on after reset", 1, pll_on_o);
      chk("read outputs float", 1, lnk.q_oe_n);
      push(12, 6);
      chk("fifo words taken", qbs_pkg::FIFO_DEPTH, pq.size());
      wr(0);
      wr(1);
      idle(8);
      chk("fifo ready when drained", 1, wr_data_ready_o);
      $display("test fifo fill done");
      for (int a = 2; a < 8; a++) begin
         push(4, 20);
         wr(AW'(a));
      end
      idle(8);
      rd(0);
      rd(1);
      rd(5);
      idle(24);
      $display("test back to back reads done");
      mk = 1;
      push(4, 20);
      wr(3);
      idle(8);
      rd(3);
      idle(24);
      $display("test lane masks done");
      pll_disable_n_i = 0;
      idle(4);
      chk("pll off seen", 0, pll_on_o);
      rd(3);
      rd(6);
      idle(24);
      pll_disable_n_i = 1;
      idle(4);
      $display("test pll off done");
      for (int n = 0; n < 40; n++) begin
         r = $random(seed);
         if (r[8]) begin
            push(4, 20);
            wr(AW'(r & 7));
            idle(8);
         end else begin
            rd(AW'(r & 7));
            if (r[9]) rd(AW'((r >> 4) & 7));
            idle(1);
         end
      end
      for (int k = 0; k < 100 && eq.size() > 0; k++) @(negedge mclk_i);
      chk("read words missing", 0, eq.size());
      chk("read burst beats", (qbs_pkg::BURST_LEN - 1) * nrd, ract);
      chk("write burst beats", (qbs_pkg::BURST_LEN - 1) * nwr, wact);
      $display("test random traffic done");
      summarize();
   end
endmodule : tb_top
`default_nettype wire
